// file: rtl/phy_reset_timer.sv
// Timed active-low reset pulse for the external Ethernet PHY
`timescale 1ns/100ps
module phy_reset_timer #(
  parameter int unsigned CYCLES = pwr_state_pkg::PHY_RST_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy_ff,
  output logic done_ff,
  output logic ext_a_b_ff
);

  localparam logic [pwr_state_pkg::PHY_CNT_W-1:0] LAST =
    pwr_state_pkg::PHY_CNT_W'(CYCLES - 1);

  logic [pwr_state_pkg::PHY_CNT_W-1:0] cnt_ff;
  logic [pwr_state_pkg::PHY_CNT_W-1:0] nxt_cnt;
  logic nxt_busy;
  wire at_end = busy_ff && (cnt_ff == LAST);

  // ==========================================================
  // Counter; a new start restarts the full interval
  assign nxt_busy = start || (busy_ff && !at_end);
  assign nxt_cnt = (start || !busy_ff) ? '0 :
                   pwr_state_pkg::PHY_CNT_W'(cnt_ff + 1'b1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ext_a_b_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= at_end && !start;
      ext_a_b_ff <= !nxt_busy;
    end
  end

endmodule

// file: rtl/pwr_state_pkg.sv
// Shared constants and types of the power-state manager
package pwr_state_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned PHY_RST_TIME_US = 4000;
  localparam int unsigned PHY_RST_CYCLES = PHY_RST_TIME_US * CLK_MHZ;
  localparam int unsigned PHY_CNT_W = 18;

  // ==========================================================
  // Register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] PWR_CTL_ADDR = 8'h00;

  // power_mgmt_control field positions
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_MSB = 1;
  localparam int unsigned PHY_RST_BIT = 2;
  localparam int unsigned EEE_RX_EN_BIT = 3;
  localparam int unsigned EEE_TX_EN_BIT = 4;
  localparam int unsigned FILT_WAKE_BIT = 5;
  localparam int unsigned READY_BIT = 7;
  localparam int unsigned STATE_LSB = 8;
  localparam int unsigned STATE_MSB = 11;

  // Suspend-mode encodings
  localparam logic [1:0] MODE_SLEEP0 = 2'h0;
  localparam logic [1:0] MODE_SLEEP2 = 2'h2;
  localparam logic [1:0] MODE_SLEEP3 = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_SLEEP2;
  localparam logic EN_RESET = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_BOOT,
    ST_UNPOWERED,
    ST_PLL_START,
    ST_NORM_UNCONF,
    ST_NORM_CONF,
    ST_SLEEP0,
    ST_SLEEP2,
    ST_SLEEP3
  } pwr_state_t;

  typedef struct packed {
    logic gpio;
    logic wol;
    logic eee_receive_wake_flag;
    logic eee_transmit_wake_flag;
    logic frame_good;
    logic filter_pass;
  } wake_events_t;

  typedef struct packed {
    logic osc;
    logic pll;
    logic phy;
    logic afe;
    logic subset_clk;
    logic all_clk;
  } power_enables_t;

endpackage

// file: rtl/usb_ethernet_power_state_manager.sv
// Power-state manager: states, clock enables, suspend and wake
// ==========================================================
`timescale 1ns/100ps
module usb_ethernet_power_state_manager #(
  parameter int unsigned PHY_RST_CYCLES = pwr_state_pkg::PHY_RST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic usb_power_detect,
  input wire logic pll_locked,
  input wire logic usb_suspend,
  input wire logic usb_resume,
  input wire logic usb_reset,
  input wire logic ext_reset_b,
  input wire logic set_config,
  input wire logic set_config_value,
  input wire pwr_state_pkg::wake_events_t wake_in,
  input wire logic [pwr_state_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pwr_state_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pwr_state_pkg::DATA_W-1:0] reg_rdata_ff,
  output pwr_state_pkg::power_enables_t enables_ff,
  output logic ext_a_b,
  output logic ready_ff,
  output logic rx_store_ff,
  output logic wake_notify_ff
);

  // ==========================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_b <= rst_meta_ff;
    end
  end

  // ==========================================================
  // Register decode
  logic [1:0] mode_ff;
  logic eee_rx_en_ff;
  logic eee_tx_en_ff;
  logic filt_wake_ff;
  pwr_state_pkg::pwr_state_t state_ff;
  pwr_state_pkg::pwr_state_t nxt_state;

  wire ctl_hit = (reg_addr == pwr_state_pkg::PWR_CTL_ADDR);
  wire ctl_wr = reg_wr && ctl_hit;
  wire ctl_rd = reg_rd && ctl_hit;
  wire sw_phy_rst = ctl_wr && reg_wdata[pwr_state_pkg::PHY_RST_BIT];

  logic [pwr_state_pkg::DATA_W-1:0] ctl_view;
  always_comb begin
    ctl_view = '0;
    ctl_view[pwr_state_pkg::MODE_MSB:pwr_state_pkg::MODE_LSB] = mode_ff;
    ctl_view[pwr_state_pkg::EEE_RX_EN_BIT] = eee_rx_en_ff;
    ctl_view[pwr_state_pkg::EEE_TX_EN_BIT] = eee_tx_en_ff;
    ctl_view[pwr_state_pkg::FILT_WAKE_BIT] = filt_wake_ff;
    ctl_view[pwr_state_pkg::READY_BIT] = ready_ff;
    ctl_view[pwr_state_pkg::STATE_MSB:pwr_state_pkg::STATE_LSB] = state_ff;
  end

  wire [pwr_state_pkg::DATA_W-1:0] nxt_rdata = ctl_rd ? ctl_view : '0;

  // ==========================================================
  // Events
  wire in_sleep = (state_ff == pwr_state_pkg::ST_SLEEP0) ||
                  (state_ff == pwr_state_pkg::ST_SLEEP2) ||
                  (state_ff == pwr_state_pkg::ST_SLEEP3);
  wire in_normal = (state_ff == pwr_state_pkg::ST_NORM_UNCONF) ||
                   (state_ff == pwr_state_pkg::ST_NORM_CONF);
  wire powered = in_sleep || in_normal ||
                 (state_ff == pwr_state_pkg::ST_PLL_START);
  wire hard_reset = powered && (usb_reset || !ext_reset_b);
  wire deconfig = (state_ff == pwr_state_pkg::ST_NORM_CONF) &&
                  set_config && !set_config_value;
  // A USB reset or reset pin (hard reset) also forces the mode, as deconfiguration does
  wire force_mode = deconfig || hard_reset;

  wire eee_wake = (wake_in.eee_receive_wake_flag && eee_rx_en_ff) ||
                  (wake_in.eee_transmit_wake_flag && eee_tx_en_ff);
  wire good_frame = filt_wake_ff && wake_in.frame_good &&
                    wake_in.filter_pass;
  wire wake_s0 = wake_in.gpio || wake_in.wol || eee_wake;
  wire wake_s2 = wake_in.gpio;
  wire wake_s3 = wake_in.gpio || wake_in.wol || eee_wake || good_frame;
  wire wake_now = ((state_ff == pwr_state_pkg::ST_SLEEP0) && wake_s0) ||
                  ((state_ff == pwr_state_pkg::ST_SLEEP2) && wake_s2) ||
                  ((state_ff == pwr_state_pkg::ST_SLEEP3) && wake_s3);

  // Suspend target follows only USB suspend/U3, never U1/U2/L1
  logic [1:0] mode_pick;
  assign mode_pick = mode_ff;
  wire pwr_state_pkg::pwr_state_t conf_target =
    (mode_pick == pwr_state_pkg::MODE_SLEEP0) ? pwr_state_pkg::ST_SLEEP0 :
    (mode_pick == pwr_state_pkg::MODE_SLEEP3) ? pwr_state_pkg::ST_SLEEP3 :
    pwr_state_pkg::ST_SLEEP2;

  // ==========================================================
  // State machine
  logic from_unconf_ff;
  logic nxt_from_unconf;

  always_comb begin
    nxt_state = state_ff;
    nxt_from_unconf = from_unconf_ff;
    if (!usb_power_detect && state_ff != pwr_state_pkg::ST_BOOT) begin
      nxt_state = pwr_state_pkg::ST_UNPOWERED;
    end else if (hard_reset) begin
      nxt_state = pwr_state_pkg::ST_NORM_UNCONF;
    end else begin
      case (state_ff)
        pwr_state_pkg::ST_BOOT: begin
          nxt_state = usb_power_detect ? pwr_state_pkg::ST_PLL_START :
                      pwr_state_pkg::ST_UNPOWERED;
        end
        pwr_state_pkg::ST_UNPOWERED: begin
          nxt_state = pwr_state_pkg::ST_PLL_START;
        end
        pwr_state_pkg::ST_PLL_START: begin
          if (pll_locked) begin
            nxt_state = pwr_state_pkg::ST_NORM_UNCONF;
          end
        end
        pwr_state_pkg::ST_NORM_UNCONF: begin
          if (usb_suspend) begin
            nxt_state = pwr_state_pkg::ST_SLEEP2;
            nxt_from_unconf = 1'b1;
          end else if (set_config && set_config_value) begin
            nxt_state = pwr_state_pkg::ST_NORM_CONF;
          end
        end
        pwr_state_pkg::ST_NORM_CONF: begin
          if (usb_suspend) begin
            nxt_state = conf_target;
            nxt_from_unconf = 1'b0;
          end else if (deconfig) begin
            nxt_state = pwr_state_pkg::ST_NORM_UNCONF;
          end
        end
        default: begin
          if (usb_resume || wake_now) begin
            nxt_state = from_unconf_ff ? pwr_state_pkg::ST_NORM_UNCONF :
                        pwr_state_pkg::ST_NORM_CONF;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Clock and power enables per state
  pwr_state_pkg::power_enables_t nxt_en;
  always_comb begin
    nxt_en = '0;
    case (nxt_state)
      pwr_state_pkg::ST_UNPOWERED: begin
        nxt_en = '0;
      end
      pwr_state_pkg::ST_BOOT: begin
        nxt_en.osc = 1'b1;
      end
      pwr_state_pkg::ST_PLL_START: begin
        nxt_en.osc = 1'b1;
        nxt_en.pll = 1'b1;
      end
      pwr_state_pkg::ST_NORM_UNCONF: begin
        nxt_en = '{osc: 1'b1, pll: 1'b1, phy: 1'b1, afe: 1'b1,
                   subset_clk: 1'b1, all_clk: 1'b0};
      end
      pwr_state_pkg::ST_NORM_CONF: begin
        nxt_en = '1;
      end
      pwr_state_pkg::ST_SLEEP0: begin
        nxt_en.osc = 1'b1;
        nxt_en.phy = 1'b1;
      end
      pwr_state_pkg::ST_SLEEP3: begin
        nxt_en = '{osc: 1'b1, pll: 1'b1, phy: 1'b1, afe: 1'b0,
                   subset_clk: 1'b1, all_clk: 1'b1};
      end
      default: begin
        nxt_en.osc = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // PHY reset pulse and ready flag
  wire power_gain = (state_ff == pwr_state_pkg::ST_UNPOWERED) &&
                    usb_power_detect;
  wire boot_done = (state_ff == pwr_state_pkg::ST_BOOT) &&
                   usb_power_detect;
  logic phy_start_ff;
  logic phy_busy;
  logic phy_done;
  wire nxt_phy_start = boot_done || power_gain || hard_reset ||
                       sw_phy_rst;

  phy_reset_timer #(
    .CYCLES(PHY_RST_CYCLES)
  ) u_phy_reset_timer (
    .clk(sys_clk),
    .rst_b(rst_sync_b),
    .start(phy_start_ff),
    .busy_ff(phy_busy),
    .done_ff(),
    .ext_a_b_ff(ext_a_b)
  );
  assign phy_done = !phy_busy && !phy_start_ff;

  wire nxt_ready = (nxt_state == pwr_state_pkg::ST_NORM_CONF ||
                    nxt_state == pwr_state_pkg::ST_NORM_UNCONF) &&
                   phy_done && !nxt_phy_start;

  // ==========================================================
  // Frame storing in sleep three
  wire s3_wake_frame = (state_ff == pwr_state_pkg::ST_SLEEP3) &&
                       (wake_in.wol || good_frame);
  wire nxt_store = !hard_reset && powered &&
                   (s3_wake_frame || (rx_store_ff && !usb_resume));

  wire nxt_notify = wake_now && !usb_resume && !hard_reset &&
                    usb_power_detect;

  // ==========================================================
  // Control register and state flops
  logic [1:0] nxt_mode;
  assign nxt_mode = force_mode ? pwr_state_pkg::MODE_RESET :
    ctl_wr ? reg_wdata[pwr_state_pkg::MODE_MSB:pwr_state_pkg::MODE_LSB] :
    mode_ff;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_ff <= pwr_state_pkg::ST_BOOT;
      from_unconf_ff <= 1'b0;
      mode_ff <= pwr_state_pkg::MODE_RESET;
      eee_rx_en_ff <= pwr_state_pkg::EN_RESET;
      eee_tx_en_ff <= pwr_state_pkg::EN_RESET;
      filt_wake_ff <= pwr_state_pkg::EN_RESET;
      enables_ff <= '0;
      phy_start_ff <= 1'b0;
      ready_ff <= 1'b0;
      rx_store_ff <= 1'b0;
      wake_notify_ff <= 1'b0;
      reg_rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      from_unconf_ff <= nxt_from_unconf;
      mode_ff <= nxt_mode;
      if (ctl_wr) begin
        eee_rx_en_ff <= reg_wdata[pwr_state_pkg::EEE_RX_EN_BIT];
        eee_tx_en_ff <= reg_wdata[pwr_state_pkg::EEE_TX_EN_BIT];
        filt_wake_ff <= reg_wdata[pwr_state_pkg::FILT_WAKE_BIT];
      end
      enables_ff <= nxt_en;
      phy_start_ff <= nxt_phy_start;
      ready_ff <= nxt_ready;
      rx_store_ff <= nxt_store;
      wake_notify_ff <= nxt_notify;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Checks
  a_unpow_all_off: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    state_ff == pwr_state_pkg::ST_UNPOWERED |-> enables_ff == '0)
    else $error("enables on while unpowered");

  a_power_loss: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (!usb_power_detect && state_ff != pwr_state_pkg::ST_BOOT) |=>
    state_ff == pwr_state_pkg::ST_UNPOWERED)
    else $error("power loss did not reach unpowered");

  a_lock_to_unconf: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (state_ff == pwr_state_pkg::ST_PLL_START && pll_locked &&
     usb_power_detect && !hard_reset) |=>
    state_ff == pwr_state_pkg::ST_NORM_UNCONF && enables_ff.pll)
    else $error("pll lock not followed by unconfigured");

  a_osc_powered: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (in_sleep || in_normal) |-> ##1 enables_ff.osc || !usb_power_detect ||
    $past(!usb_power_detect))
    else $error("oscillator off while powered");

  a_unconf_sleep2: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (state_ff == pwr_state_pkg::ST_NORM_UNCONF && usb_suspend &&
     usb_power_detect && !hard_reset) |=>
    state_ff == pwr_state_pkg::ST_SLEEP2)
    else $error("unconfigured suspend not to sleep two");

  a_mode_forced: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    deconfig |=> mode_ff == pwr_state_pkg::MODE_SLEEP2)
    else $error("mode not forced on deconfiguration");

  a_sleep2_gpio: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (state_ff == pwr_state_pkg::ST_SLEEP2 && !wake_in.gpio &&
     !usb_resume && !hard_reset && usb_power_detect) |=>
    state_ff == pwr_state_pkg::ST_SLEEP2)
    else $error("sleep two left without gpio or resume");

  a_reset_suspend: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (in_sleep && usb_reset && usb_power_detect) |=>
    state_ff == pwr_state_pkg::ST_NORM_UNCONF ##1 !ext_a_b)
    else $error("reset in suspend mishandled");

  a_ready_after_phy: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    !ext_a_b |-> !ready_ff)
    else $error("ready while PHY reset held");

  a_sleep0_pll_off: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    ($past(state_ff) == pwr_state_pkg::ST_SLEEP0 &&
     state_ff == pwr_state_pkg::ST_SLEEP0) |->
    (!enables_ff.pll && enables_ff.osc && enables_ff.phy))
    else $error("sleep zero enables wrong");

  a_s3_store_held: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_b)
    (rx_store_ff && !usb_resume && !hard_reset && powered &&
     usb_power_detect) |=> rx_store_ff)
    else $error("frame storing dropped before resume");

endmodule

// file: testbench/pll_lock_model.sv
// Model of the PLL beside the block: reports lock a while after enable
`timescale 1ns/100ps
module pll_lock_model #(
  parameter int unsigned LOCK_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pll_en,
  output logic locked
);
  logic [3:0] cnt_ff;
  // ==========================================================
  // Lock counter, cleared whenever the PLL is switched off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 4'h0;
    end else if (!pll_en) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff != 4'(LOCK_CYCLES)) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  assign locked = pll_en && (cnt_ff == 4'(LOCK_CYCLES));
endmodule

// file: testbench/usb_ethernet_power_state_manager_tb.sv
// Self-checking bench for the power-state manager
`timescale 1ns/100ps
module usb_ethernet_power_state_manager_tb;
  localparam int unsigned RST_CYC = 8;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic usb_power_detect = 1'b1;
  logic pll_locked;
  logic usb_suspend = 1'b0;
  logic usb_resume = 1'b0;
  logic usb_reset = 1'b0;
  logic ext_reset_b = 1'b1;
  logic set_config = 1'b0;
  logic set_config_value = 1'b0;
  pwr_state_pkg::wake_events_t wake_in = '0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  pwr_state_pkg::power_enables_t enables_ff;
  logic ext_a_b;
  logic ready_ff;
  logic rx_store_ff;
  logic wake_notify_ff;
  int errors = 0;
  int n_tests = 0;
  int n_wake = 0;
  logic [31:0] rd;

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wake_notify_ff) n_wake++;

  usb_ethernet_power_state_manager #(.PHY_RST_CYCLES(RST_CYC)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .usb_power_detect(usb_power_detect),
    .pll_locked(pll_locked), .usb_suspend(usb_suspend),
    .usb_resume(usb_resume), .usb_reset(usb_reset),
    .ext_reset_b(ext_reset_b), .set_config(set_config),
    .set_config_value(set_config_value), .wake_in(wake_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .enables_ff(enables_ff),
    .ext_a_b(ext_a_b), .ready_ff(ready_ff), .rx_store_ff(rx_store_ff),
    .wake_notify_ff(wake_notify_ff)
  );

  pll_lock_model pll_u (
    .clk(sys_clk), .rst_b(rst_b), .pll_en(enables_ff.pll),
    .locked(pll_locked)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata_ff;
  endtask

  task automatic chk_state(input logic [3:0] s, input string m);
    rdw(8'h00);
    check({28'h0, rd[11:8]}, {28'h0, s}, m);
  endtask

  task automatic wait_state(input logic [3:0] s);
    for (int i = 0; i < 40; i++) begin
      rdw(8'h00);
      if (rd[11:8] === s) return;
    end
    check({28'h0, rd[11:8]}, {28'h0, s}, "state wait");
    summarize();
  endtask

  task automatic wait_ready;
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      #1;
      if (ready_ff === 1'b1) break;
    end
    check(32'(ready_ff), 32'h1, "ready");
    check(32'(ext_a_b), 32'h1, "phy reset over at ready");
    if (ready_ff !== 1'b1) begin
      summarize();
    end
  endtask

  task automatic pulse_cfg(input logic v, input logic [3:0] s);
    @(posedge sys_clk);
    set_config <= 1'b1;
    set_config_value <= v;
    @(posedge sys_clk);
    set_config <= 1'b0;
    chk_state(s, "set config");
  endtask

  task automatic suspend_to(input logic [31:0] d, input logic [3:0] s);
    wr(8'h00, d);
    @(posedge sys_clk);
    usb_suspend <= 1'b1;
    @(posedge sys_clk);
    usb_suspend <= 1'b0;
    chk_state(s, "suspend target");
  endtask

  task automatic resume_to(input logic [3:0] s);
    @(posedge sys_clk);
    usb_resume <= 1'b1;
    @(posedge sys_clk);
    usb_resume <= 1'b0;
    chk_state(s, "resume");
  endtask

  task automatic wake(input logic [5:0] w, input logic [3:0] s);
    @(posedge sys_clk);
    wake_in <= w;
    @(posedge sys_clk);
    wake_in <= '0;
    chk_state(s, "wake event");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_power_up;
    repeat (3) @(posedge sys_clk);
    wait_state(pwr_state_pkg::ST_PLL_START);
    check(32'(enables_ff), 32'(6'h30), "pll start enables");
    check(32'(ext_a_b), 32'h0, "phy reset low");
    check(32'(ready_ff), 32'h0, "not ready");
    wait_state(pwr_state_pkg::ST_NORM_UNCONF);
    check(32'(enables_ff), 32'(6'h3e), "unconf enables");
    check({30'h0, rd[1:0]}, 32'(pwr_state_pkg::MODE_RESET), "mode");
    wait_ready();
    pulse_cfg(1'b1, pwr_state_pkg::ST_NORM_CONF);
    check(32'(enables_ff), 32'(6'h3f), "conf enables");
    check(32'(ready_ff), 32'h1, "ready kept");
  endtask

  task automatic t_sleep_modes;
    int w0;
    suspend_to(32'h0, pwr_state_pkg::ST_SLEEP0);
    check(32'(enables_ff.pll), 32'h0, "s0 pll off");
    check(32'(enables_ff.osc), 32'h1, "s0 osc on");
    wake(6'h10, pwr_state_pkg::ST_NORM_CONF);
    check(32'(enables_ff), 32'(6'h3f), "wol clocks");
    suspend_to(32'h2, pwr_state_pkg::ST_SLEEP2);
    check(32'(enables_ff.osc), 32'h1, "s2 osc on");
    wake(6'h10, pwr_state_pkg::ST_SLEEP2);
    w0 = n_wake;
    wake(6'h20, pwr_state_pkg::ST_NORM_CONF);
    check(32'(n_wake - w0), 32'h1, "one wake notify");
    suspend_to(32'h3, pwr_state_pkg::ST_SLEEP3);
    check(32'(enables_ff.afe), 32'h0, "s3 afe off");
    check(32'(enables_ff.osc), 32'h1, "s3 osc on");
    wake(6'h0c, pwr_state_pkg::ST_SLEEP3);
    resume_to(pwr_state_pkg::ST_NORM_CONF);
    suspend_to(32'h0b, pwr_state_pkg::ST_SLEEP3);
    wake(6'h08, pwr_state_pkg::ST_NORM_CONF);
    suspend_to(32'h13, pwr_state_pkg::ST_SLEEP3);
    wake(6'h04, pwr_state_pkg::ST_NORM_CONF);
    suspend_to(32'h23, pwr_state_pkg::ST_SLEEP3);
    wake(6'h03, pwr_state_pkg::ST_NORM_CONF);
    check(32'(rx_store_ff), 32'h1, "frames stored");
    resume_to(pwr_state_pkg::ST_NORM_CONF);
    check(32'(rx_store_ff), 32'h0, "store ends");
  endtask

  task automatic t_deconfig;
    wr(8'h00, 32'h3);
    pulse_cfg(1'b0, pwr_state_pkg::ST_NORM_UNCONF);
    check({30'h0, rd[1:0]}, 32'h2, "mode forced");
    suspend_to(32'h3, pwr_state_pkg::ST_SLEEP2);
    resume_to(pwr_state_pkg::ST_NORM_UNCONF);
    suspend_to(32'h3, pwr_state_pkg::ST_SLEEP2);
    wake(6'h20, pwr_state_pkg::ST_NORM_UNCONF);
  endtask

  task automatic t_hard_reset;
    pulse_cfg(1'b1, pwr_state_pkg::ST_NORM_CONF);
    suspend_to(32'h0, pwr_state_pkg::ST_SLEEP0);
    @(posedge sys_clk);
    usb_reset <= 1'b1;
    @(posedge sys_clk);
    usb_reset <= 1'b0;
    chk_state(pwr_state_pkg::ST_NORM_UNCONF, "usb reset");
    check({30'h0, rd[1:0]}, 32'h2, "mode after reset");
    pulse_cfg(1'b1, pwr_state_pkg::ST_NORM_CONF);
    suspend_to(32'h3, pwr_state_pkg::ST_SLEEP3);
    @(posedge sys_clk);
    ext_reset_b <= 1'b0;
    @(posedge sys_clk);
    ext_reset_b <= 1'b1;
    chk_state(pwr_state_pkg::ST_NORM_UNCONF, "reset pin");
    wait_ready();
  endtask

  task automatic t_regs_phy;
    int n_low = 0;
    wr(8'h04, 32'h1);
    rdw(8'h04);
    check(rd, 32'h0, "unmapped read");
    wr(8'h00, 32'h6);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      if (ext_a_b === 1'b0) n_low++;
      if (i == 1) begin
        check(32'(ext_a_b), 32'h0, "phy reset by bit");
        check(32'(ready_ff), 32'h0, "ready waits");
      end
    end
    check(32'(n_low), 32'(RST_CYC), "phy reset length");
    rdw(8'h00);
    check({29'h0, rd[2:0]}, 32'h2, "bit reads 0, mode kept");
    wait_ready();
  endtask

  task automatic t_power_loss;
    @(posedge sys_clk);
    usb_power_detect <= 1'b0;
    chk_state(pwr_state_pkg::ST_UNPOWERED, "power lost");
    check(32'(enables_ff), 32'h0, "all off");
    repeat (20) @(posedge sys_clk);
    chk_state(pwr_state_pkg::ST_UNPOWERED, "stays unpowered");
    @(posedge sys_clk);
    usb_power_detect <= 1'b1;
    wait_state(pwr_state_pkg::ST_NORM_UNCONF);
    wait_ready();
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_power_up();
    t_sleep_modes();
    t_deconfig();
    t_hard_reset();
    t_regs_phy();
    t_power_loss();
    summarize();
  end
endmodule
